// file: wdt_map.svh
// register offsets, field positions, keys and period shift amounts of the watchdog
`ifndef WDT_MAP_SVH
`define WDT_MAP_SVH

`define WDT_ADDR_W          8
`define WDT_CTRL_ADDR       8'h00
`define WDT_ARM_ADDR        8'h04
`define WDT_STAT_ADDR       8'h08
`define WDT_IRQ_STAT_ADDR   8'h0C
`define WDT_IRQ_MASK_ADDR   8'h10
`define WDT_COUNT_ADDR      8'h14

`define WDT_CTRL_PER_LSB    0
`define WDT_CTRL_PER_MSB    2
`define WDT_CTRL_CLK_LSB    3
`define WDT_CTRL_CLK_MSB    4
`define WDT_CTRL_AUX_BIT    5
`define WDT_CTRL_WIN_BIT    6
`define WDT_CTRL_MASK_BIT   7

`define WDT_KEY_FIRST       8'h55
`define WDT_KEY_SECOND      8'hAA
`define WDT_PER_OFF         3'h0
`define WDT_CLKSEL_IRC      2'h0
`define WDT_CLKSEL_OSC      2'h1

`define WDT_EV_TIMEOUT      0
`define WDT_EV_BADKEY       1
`define WDT_EV_EARLY        2
`define WDT_EV_SERVICE      3
`define WDT_EV_REFUSED      4
`define WDT_EV_W            5

`define WDT_BASE_SHIFT      12
`define WDT_SHIFT_STEP      2

`define WDT_RESP_OKAY       2'h0
`define WDT_RESP_SLVERR     2'h2

`endif

// file: wdt_pkg.sv
// types of the windowed watchdog: phase enum and the packed state record
`include "wdt_map.svh"

package wdt_pkg;

  typedef enum logic [0:0] {
    WDT_PH_LOAD,
    WDT_PH_RUN
  } wdt_phase_t;

  typedef struct packed {
    wdt_phase_t             phase;
    logic [2:0]             period_sel;
    logic                   window_en;
    logic [1:0]             clk_sel;
    logic                   stop_aux;
    logic                   once_done;
    logic                   pre_on;
    logic                   expect_aa;
    logic [31:0]            count;
    logic [`WDT_EV_W-1:0]   irq_stat;
    logic [`WDT_EV_W-1:0]   irq_mask;
    logic [2:0]             cause;
    logic                   wdt_rst;
    logic                   irq;
    logic                   aw_held;
    logic [`WDT_ADDR_W-1:0] aw_addr;
    logic                   w_held;
    logic [31:0]            wdata;
    logic [3:0]             wstrb;
    logic                   awready;
    logic                   wready;
    logic                   bvalid;
    logic [1:0]             bresp;
    logic                   arready;
    logic                   rvalid;
    logic [31:0]            rdata;
    logic [1:0]             rresp;
  } wdt_state_t;

endpackage : wdt_pkg

// file: wdt_watchdog.sv
// windowed watchdog timer with key servicing and an AXI4-Lite register slave
`timescale 1ns/1ns
`default_nettype none
`include "wdt_map.svh"

module wdt_watchdog
  import wdt_pkg::*;
#(
  parameter int BASE_SHIFT = `WDT_BASE_SHIFT
) (
  input  wire logic                   aclk,
  input  wire logic                   aresetn,
  input  wire logic                   clk_en,
  input  wire logic                   normal_mode,
  input  wire logic                   nvm_valid,
  input  wire logic [2:0]             nvm_period_sel,
  input  wire logic                   nvm_window_enable,
  input  wire logic                   irc_tick,
  input  wire logic                   osc_tick,
  input  wire logic [`WDT_ADDR_W-1:0] s_axi_awaddr,
  input  wire logic [2:0]             s_axi_awprot,
  input  wire logic                   s_axi_awvalid,
  output logic                        s_axi_awready,
  input  wire logic [31:0]            s_axi_wdata,
  input  wire logic [3:0]             s_axi_wstrb,
  input  wire logic                   s_axi_wvalid,
  output logic                        s_axi_wready,
  output logic [1:0]                  s_axi_bresp,
  output logic                        s_axi_bvalid,
  input  wire logic                   s_axi_bready,
  input  wire logic [`WDT_ADDR_W-1:0] s_axi_araddr,
  input  wire logic [2:0]             s_axi_arprot,
  input  wire logic                   s_axi_arvalid,
  output logic                        s_axi_arready,
  output logic [31:0]                 s_axi_rdata,
  output logic [1:0]                  s_axi_rresp,
  output logic                        s_axi_rvalid,
  input  wire logic                   s_axi_rready,
  output logic                        wdt_reset,
  output logic                        irq
);

  wdt_state_t s;
  wdt_state_t next_s;

  // period length in ticks for a select code
  function automatic logic [31:0] period_of(input logic [2:0] code);
    logic [31:0] sh;
    sh = 32'(BASE_SHIFT) + 32'(`WDT_SHIFT_STEP) * 32'(code);
    if (code == `WDT_PER_OFF) begin
      period_of = 32'h0;
    end else begin
      period_of = 32'h1 << sh[4:0];
    end
  endfunction : period_of

  // start of the final quarter of a period
  function automatic logic [31:0] window_of(input logic [2:0] code);
    logic [31:0] p;
    p = period_of(code);
    window_of = p - (p >> 2);
  endfunction : window_of

  // control register read image
  function automatic logic [31:0] ctrl_image(input wdt_state_t st);
    logic [31:0] v;
    v = 32'h0;
    v[`WDT_CTRL_PER_MSB:`WDT_CTRL_PER_LSB] = st.period_sel;
    v[`WDT_CTRL_CLK_MSB:`WDT_CTRL_CLK_LSB] = st.clk_sel;
    v[`WDT_CTRL_AUX_BIT] = st.stop_aux;
    v[`WDT_CTRL_WIN_BIT] = st.window_en;
    ctrl_image = v;
  endfunction : ctrl_image

  logic [31:0]          period;
  logic [31:0]          win_start;
  logic                 enabled;
  logic                 tick;
  logic [`WDT_EV_W-1:0] ev;
  logic                 do_write;
  logic [7:0]           wbyte;
  logic [`WDT_EV_W-1:0] stat_base;

  assign period    = period_of(s.period_sel);
  assign win_start = window_of(s.period_sel);
  assign enabled   = (s.period_sel != `WDT_PER_OFF);
  assign wbyte     = s.wdata[7:0];

  always_comb begin
    next_s = s;
    ev = '0;
    do_write = 1'b0;
    stat_base = s.irq_stat;
    tick = 1'b0;
    next_s.wdt_rst = 1'b0;

    // preload at release, clock select forced to the IRC
    case (s.phase)
      WDT_PH_LOAD: begin
        next_s.phase = WDT_PH_RUN;
        next_s.clk_sel = `WDT_CLKSEL_IRC;
        if (normal_mode && nvm_valid) begin
          next_s.period_sel = nvm_period_sel;
          next_s.window_en = nvm_window_enable;
          next_s.pre_on = (nvm_period_sel != `WDT_PER_OFF);
        end else begin
          next_s.period_sel = `WDT_PER_OFF;
          next_s.window_en = 1'b0;
          next_s.pre_on = 1'b0;
        end
      end
      WDT_PH_RUN: begin
      end
      default: begin
        next_s.phase = WDT_PH_LOAD;
      end
    endcase

    // timebase from the selected source
    case (s.clk_sel)
      `WDT_CLKSEL_IRC: tick = irc_tick;
      `WDT_CLKSEL_OSC: tick = osc_tick;
      default:         tick = irc_tick;
    endcase

    if (s.phase == WDT_PH_RUN && enabled && tick) begin
      if (s.count + 32'h1 >= period) begin
        ev[`WDT_EV_TIMEOUT] = 1'b1;
      end else begin
        next_s.count = s.count + 32'h1;
      end
    end

    // write address and data channels, either order
    if (s_axi_awvalid && s.awready) begin
      next_s.aw_held = 1'b1;
      next_s.aw_addr = s_axi_awaddr;
      next_s.awready = 1'b0;
    end
    if (s_axi_wvalid && s.wready) begin
      next_s.w_held = 1'b1;
      next_s.wdata = s_axi_wdata;
      next_s.wstrb = s_axi_wstrb;
      next_s.wready = 1'b0;
    end

    do_write = s.aw_held && s.w_held && !s.bvalid;
    if (do_write) begin
      next_s.aw_held = 1'b0;
      next_s.w_held = 1'b0;
      next_s.bvalid = 1'b1;
      next_s.bresp = `WDT_RESP_OKAY;
      case (s.aw_addr)
        `WDT_CTRL_ADDR: begin
          if (s.wstrb[0]) begin
            if (!(normal_mode && s.once_done)) begin
              next_s.clk_sel =
                wbyte[`WDT_CTRL_CLK_MSB:`WDT_CTRL_CLK_LSB];
              next_s.stop_aux = wbyte[`WDT_CTRL_AUX_BIT];
            end
            if (wbyte[`WDT_CTRL_MASK_BIT]) begin
              next_s.once_done = s.once_done;
            end else if (normal_mode && s.once_done) begin
              ev[`WDT_EV_REFUSED] = 1'b1;
            end else begin
              next_s.window_en = wbyte[`WDT_CTRL_WIN_BIT];
              if (s.pre_on &&
                  wbyte[`WDT_CTRL_PER_MSB:`WDT_CTRL_PER_LSB] == `WDT_PER_OFF) begin
                ev[`WDT_EV_REFUSED] = 1'b1;
              end else begin
                next_s.period_sel =
                  wbyte[`WDT_CTRL_PER_MSB:`WDT_CTRL_PER_LSB];
              end
              next_s.count = 32'h0;
              next_s.once_done = normal_mode;
            end
          end
        end
        `WDT_ARM_ADDR: begin
          if (s.wstrb[0] && enabled && s.phase == WDT_PH_RUN) begin
            if (s.window_en && s.count < win_start) begin
              ev[`WDT_EV_EARLY] = 1'b1;
            end else if (wbyte == `WDT_KEY_FIRST) begin
              next_s.expect_aa = 1'b1;
            end else if (wbyte == `WDT_KEY_SECOND) begin
              if (s.expect_aa) begin
                next_s.count = 32'h0;
                next_s.expect_aa = 1'b0;
                ev[`WDT_EV_SERVICE] = 1'b1;
              end
            end else begin
              ev[`WDT_EV_BADKEY] = 1'b1;
            end
          end
        end
        `WDT_IRQ_MASK_ADDR: begin
          if (s.wstrb[0]) begin
            next_s.irq_mask = s.wdata[`WDT_EV_W-1:0];
          end
        end
        `WDT_STAT_ADDR,
        `WDT_IRQ_STAT_ADDR,
        `WDT_COUNT_ADDR: begin
        end
        default: begin
          next_s.bresp = `WDT_RESP_SLVERR;
        end
      endcase
    end

    if (s.bvalid && s_axi_bready) begin
      next_s.bvalid = 1'b0;
      next_s.awready = 1'b1;
      next_s.wready = 1'b1;
    end

    // read channel, one outstanding read
    if (s_axi_arvalid && s.arready) begin
      next_s.arready = 1'b0;
      next_s.rvalid = 1'b1;
      next_s.rresp = `WDT_RESP_OKAY;
      next_s.rdata = 32'h0;
      case (s_axi_araddr)
        `WDT_CTRL_ADDR: begin
          next_s.rdata = ctrl_image(s);
        end
        `WDT_ARM_ADDR: begin
          next_s.rdata = 32'h0;
        end
        `WDT_STAT_ADDR: begin
          next_s.rdata = {26'h0, s.expect_aa, s.once_done,
                          s.pre_on, s.cause};
        end
        `WDT_IRQ_STAT_ADDR: begin
          next_s.rdata = {{(32-`WDT_EV_W){1'b0}}, s.irq_stat};
          stat_base = '0;
        end
        `WDT_IRQ_MASK_ADDR: begin
          next_s.rdata = {{(32-`WDT_EV_W){1'b0}}, s.irq_mask};
        end
        `WDT_COUNT_ADDR: begin
          next_s.rdata = s.count;
        end
        default: begin
          next_s.rresp = `WDT_RESP_SLVERR;
        end
      endcase
    end
    if (s.rvalid && s_axi_rready) begin
      next_s.rvalid = 1'b0;
      next_s.arready = 1'b1;
    end

    // a watchdog reset restarts the period and the key tracker
    if (ev[`WDT_EV_TIMEOUT] || ev[`WDT_EV_BADKEY] || ev[`WDT_EV_EARLY]) begin
      next_s.wdt_rst = 1'b1;
      next_s.count = 32'h0;
      next_s.expect_aa = 1'b0;
      next_s.cause = ev[2:0];
    end

    // new events win over the read clear
    next_s.irq_stat = stat_base | ev;
    next_s.irq = |(next_s.irq_stat & next_s.irq_mask);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s <= '0;
      s.awready <= 1'b1;
      s.wready <= 1'b1;
      s.arready <= 1'b1;
    end else if (clk_en) begin
      s <= next_s;
    end
  end

  assign s_axi_awready = s.awready;
  assign s_axi_wready  = s.wready;
  assign s_axi_bvalid  = s.bvalid;
  assign s_axi_bresp   = s.bresp;
  assign s_axi_arready = s.arready;
  assign s_axi_rvalid  = s.rvalid;
  assign s_axi_rdata   = s.rdata;
  assign s_axi_rresp   = s.rresp;
  assign wdt_reset     = s.wdt_rst;
  assign irq           = s.irq;

  logic unused_prot;
  assign unused_prot = ^{s_axi_awprot, s_axi_arprot};

endmodule : wdt_watchdog
`default_nettype wire

// file: wdt_watchdog_monitor.sv
// assertion checker on the watchdog bus and reset ports
`timescale 1ns/1ns
`default_nettype none
`include "wdt_map.svh"
module wdt_watchdog_monitor (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic [7:0]  s_axi_awaddr,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [7:0]  s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic        wdt_reset
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  wire aw_w = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  wire ar_h = s_axi_arvalid && s_axi_arready;
  property p_rst_pulse; wdt_reset |=> !wdt_reset; endproperty
  a_rst_pulse: assert property (p_rst_pulse) else $error("reset pulse too long");
  property p_b_lat; aw_w |=> !s_axi_bvalid ##1 s_axi_bvalid; endproperty
  a_b_lat: assert property (p_b_lat) else $error("write answer late");
  property p_unmap; aw_w && s_axi_awaddr > `WDT_COUNT_ADDR |=> ##1 s_axi_bresp == `WDT_RESP_SLVERR; endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped write not refused");
  property p_b_done; s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid; endproperty
  a_b_done: assert property (p_b_done) else $error("write answer repeated");
  property p_r_lat; ar_h |=> s_axi_rvalid; endproperty
  a_r_lat: assert property (p_r_lat) else $error("read answer late");
  property p_r_done; s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid; endproperty
  a_r_done: assert property (p_r_done) else $error("read answer repeated");
  property p_ar_block; s_axi_rvalid |-> !s_axi_arready; endproperty
  a_ar_block: assert property (p_ar_block) else $error("read taken while busy");
  property p_mask_rd0; ar_h && s_axi_araddr == `WDT_CTRL_ADDR |=> !s_axi_rdata[`WDT_CTRL_MASK_BIT]; endproperty
  a_mask_rd0: assert property (p_mask_rd0) else $error("write mask bit read back");
endmodule : wdt_watchdog_monitor

bind wdt_watchdog wdt_watchdog_monitor i_mon (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .wdt_reset);
`default_nettype wire

// file: tb.sv
// self-checking bench for the windowed watchdog
`timescale 1ns/1ns
`default_nettype none
`include "wdt_map.svh"
`define TB_CHK(a, b) begin \
  checks++; \
  if ((a) !== (b)) begin \
    err_count++; \
    $display("ERROR t=%0t got=%h exp=%h", $time, (a), (b)); \
  end \
end
module tb;
  localparam logic [7:0] A_CTL = `WDT_CTRL_ADDR;
  localparam logic [7:0] A_ARM = `WDT_ARM_ADDR;
  localparam logic [7:0] A_ST  = `WDT_STAT_ADDR;
  localparam logic [7:0] A_IS  = `WDT_IRQ_STAT_ADDR;
  localparam logic [7:0] A_IM  = `WDT_IRQ_MASK_ADDR;
  logic        aclk = 1'h0, aresetn = 1'h0, normal_mode = 1'h0, nvm_valid = 1'h0, nvm_window_enable = 1'h1;
  logic        irc_tick = 1'h0, osc_tick = 1'h0, s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0;
  logic        s_axi_bready = 1'h0, s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, wdt_reset, irq;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
  logic [2:0]  nvm_period_sel = 3'h5;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rdv, key;
  int          err_count = 0, checks = 0, nrst = 0, n0 = 0, n = 0, seed = 32'h6A7742A5;

  wdt_watchdog #(.BASE_SHIFT(0)) i_dut (
    .aclk, .aresetn, .clk_en(1'h1), .normal_mode, .nvm_valid, .nvm_period_sel, .nvm_window_enable,
    .irc_tick, .osc_tick, .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arprot(3'h0), .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .wdt_reset, .irq);

  always #5 aclk = ~aclk;

  always @(posedge aclk) begin
    irc_tick <= 1'h1;
    osc_tick <= 1'($random(seed));
    if (wdt_reset === 1'h1) nrst <= nrst + 1;
  end

  function automatic int exp_period(input int code);
    return 1 << (2 * code);
  endfunction : exp_period

  task final_report;
    $display("checks=%0d err_count=%0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : final_report

  task do_reset(input logic nm, input logic nv);
    normal_mode <= nm;
    nvm_valid <= nv;
    aresetn <= 1'h0;
    repeat (12) @(posedge aclk);
    aresetn <= 1'h1;
  endtask : do_reset

  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
    end while (s_axi_bvalid !== 1'h1);
    rsp = s_axi_bresp;
    s_axi_bready <= 1'h0;
  endtask : wr

  task cr(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
    end while (s_axi_rvalid !== 1'h1);
    rdv = s_axi_rdata;
    `TB_CHK(s_axi_rresp, `WDT_RESP_OKAY)
    s_axi_rready <= 1'h0;
    `TB_CHK(rdv & m, e)
  endtask : cr

  initial begin
    key = $random(seed);
    nvm_period_sel = 3'($random(seed)) | 3'h5;
    do_reset(1'h1, 1'h0);
    cr(A_CTL, 32'hFF, 32'h0);
    cr(A_ST, 32'h3F, 32'h0);
    wr(8'h40, 32'h1);
    `TB_CHK(rsp, `WDT_RESP_SLVERR)
    normal_mode <= 1'h0;
    for (int c = 1; c < 8; c++) begin
      wr(A_CTL, 32'(c));
      @(posedge aclk);
      n = 1;
      while (wdt_reset !== 1'h1 && n < 20000) begin
        @(posedge aclk);
        n++;
      end
      `TB_CHK(n >= exp_period(c) - 1 && n <= exp_period(c) + 3, 1'h1)
    end
    cr(A_ST, 32'h7, 32'h1);
    wr(A_CTL, 32'h4);
    wr(A_IM, 32'h2);
    n0 = nrst;
    repeat (20) begin
      wr(A_ARM, 32'h55);
      cr(A_ST, 32'h20, 32'h20);
      wr(A_ARM, 32'hAA);
    end
    `TB_CHK(nrst, n0)
    cr(A_ST, 32'h20, 32'h0);
    `TB_CHK(irq, 1'h0)
    wr(A_ARM, {key[31:4], 4'h3});
    repeat (3) @(posedge aclk);
    `TB_CHK(nrst, n0 + 1)
    `TB_CHK(irq, 1'h1)
    cr(A_IS, 32'h2, 32'h2);
    repeat (2) @(posedge aclk);
    `TB_CHK(irq, 1'h0)
    cr(A_ST, 32'h7, 32'h2);
    wr(A_IM, 32'h0);
    wr(A_CTL, 32'h44);
    n0 = nrst;
    wr(A_ARM, 32'h55);
    repeat (3) @(posedge aclk);
    `TB_CHK(nrst, n0 + 1)
    cr(A_ST, 32'h7, 32'h4);
    `TB_CHK(irq, 1'h0)
    wr(A_CTL, 32'h44);
    repeat (195) @(posedge aclk);
    wr(A_ARM, 32'h55);
    wr(A_ARM, 32'hAA);
    repeat (20) @(posedge aclk);
    `TB_CHK(nrst, n0 + 1)
    cr(A_ST, 32'h20, 32'h0);
    do_reset(1'h1, 1'h1);
    cr(A_CTL, 32'hFF, {25'h0, 4'h8, nvm_period_sel});
    wr(A_CTL, 32'h88);
    cr(A_CTL, 32'hFF, {25'h0, 4'h9, nvm_period_sel});
    wr(A_CTL, 32'h0);
    cr(A_CTL, 32'hFF, {29'h0, nvm_period_sel});
    wr(A_CTL, 32'h4B);
    cr(A_CTL, 32'hFF, {29'h0, nvm_period_sel});
    cr(A_ST, 32'h18, 32'h18);
    do_reset(1'h1, 1'h0);
    wr(A_CTL, 32'h42);
    wr(A_CTL, 32'h43);
    cr(A_CTL, 32'hFF, 32'h42);
    final_report();
  end

  initial begin
    #400000;
    err_count++;
    final_report();
  end
endmodule : tb
`default_nettype wire
